// ===== core/qaw_regs.svh
// Register offsets, field positions and reset values of the watchdog and event bank
`ifndef QAW_REGS_SVH
`define QAW_REGS_SVH

// ==========================================================
// Device register offsets on the link
`define QAW_OFF_SETUP      8'h2d
`define QAW_OFF_ANSWER     8'h2e
`define QAW_OFF_QUESTION   8'h2f
`define QAW_OFF_STATUS     8'h40
`define QAW_OFF_SUMMARY    8'h50
`define QAW_OFF_INT1       8'h51
`define QAW_OFF_INT3       8'h53
`define QAW_OFF_MASK1      8'h56
`define QAW_OFF_MASK3      8'h58

// ==========================================================
// Field positions
`define QAW_POS_ANSWER_SEL 6
`define QAW_POS_POLY_SEL   4
`define QAW_POS_ANS_ERR    6
`define QAW_POS_ANS_CNT    4
`define QAW_POS_WD_EVENT   7
`define QAW_POS_BUS_WAKE   6
`define QAW_POS_LOCAL_WAKE 5
`define QAW_POS_WAKE_ERR   4
`define QAW_POS_SILENT     2
`define QAW_POS_DOMINANT   0
`define QAW_POS_SPI_ERR    7
`define QAW_POS_ANY        7
`define QAW_POS_GRP1       6
`define QAW_POS_GRP2       5
`define QAW_POS_GRP3       4
`define QAW_POS_GRP_BUS    3
`define QAW_POS_ACTIVE     3
`define QAW_POS_SILENCE_T  2
`define QAW_POS_TXD_BLOCK  0

// ==========================================================
// Reset and fixed values
`define QAW_SEED_POWERUP   4'h5
`define QAW_Q_ENABLED      4'hc
`define QAW_CNT_ENABLED    2'h3
`define QAW_MASK1_RESET    8'hf3
`define QAW_INT1_USED      8'hf5

// ==========================================================
// Host register offsets on AXI4-Lite
`define QAW_HOFF_ADDR      12'h000
`define QAW_HOFF_WDATA     12'h004
`define QAW_HOFF_GO        12'h008
`define QAW_HOFF_STAT      12'h00c
`define QAW_HOFF_IRQ_STAT  12'h010
`define QAW_HOFF_IRQ_MASK  12'h014
`define QAW_HIRQ_DONE      0
`define QAW_HIRQ_DEVICE    1
`define QAW_RESP_OKAY      2'h0
`define QAW_RESP_SLVERR    2'h2

`endif

// ===== core/qaw_pkg.sv
// Types shared by both ends of the watchdog and event bank link
package qaw_pkg;

	// ==========================================================
	// Host link sequencer states; IDLE to REQ to WAIT flip one bit each, WAIT back to IDLE flips two
	typedef enum logic [1:0] {
		QAW_IDLE = 2'h0,
		QAW_REQ  = 2'h1,
		QAW_WAIT = 2'h3
	} qaw_host_state_t;

	// ==========================================================
	// Device end state
	typedef struct packed {
		logic [1:0] answer_sel;
		logic [1:0] poly_sel;
		logic [3:0] seed_read;
		logic [3:0] seed_used;
		logic [7:0] answer;
		logic       answer_strobe;
		logic       ans_err;
		logic [1:0] ans_cnt;
		logic [3:0] question;
		logic       wd_en_seen;
		logic [7:0] int1;
		logic [7:0] mask1;
		logic       spi_err;
		logic       mask3;
		logic       rsp_valid;
		logic [7:0] rsp_rdata;
		logic       irq;
	} qaw_dev_state_t;

	// ==========================================================
	// Host end state
	typedef struct packed {
		qaw_host_state_t fsm;
		logic [7:0]      addr;
		logic [7:0]      wdata;
		logic            write;
		logic [7:0]      rdata;
		logic            req_valid;
		logic [1:0]      irq_stat;
		logic [1:0]      irq_mask;
		logic            dev_irq_d;
		logic            irq;
		logic            have_aw;
		logic            have_w;
		logic [11:0]     aw_addr;
		logic [31:0]     w_data;
		logic [3:0]      w_strb;
		logic            awready;
		logic            wready;
		logic            bvalid;
		logic [1:0]      bresp;
		logic            arready;
		logic            rvalid;
		logic [31:0]     rdata_bus;
		logic [1:0]      rresp;
	} qaw_host_state_s_t;

endpackage : qaw_pkg

// ===== core/qaw_link_if.sv
// Register link between the host end and the device end
`timescale 1ns/1ps
interface qaw_link_if;
	logic       req_valid;
	logic       req_write;
	logic [7:0] req_addr;
	logic [7:0] req_wdata;
	logic       rsp_valid;
	logic [7:0] rsp_rdata;
	logic       irq;

	modport device (
		input  req_valid, req_write, req_addr, req_wdata,
		output rsp_valid, rsp_rdata, irq
	);
	modport host (
		output req_valid, req_write, req_addr, req_wdata,
		input  rsp_valid, rsp_rdata, irq
	);
endinterface : qaw_link_if

// ===== core/qaw_device_end.sv
// Device end: watchdog setup, answer, question, status, summary and event registers
`timescale 1ns/1ps
// ==========================================================
// How it works
// - Seed reads zero after power-up, uses 101b
// - Seed loads question generator in reset state
// - Answer and polynomial selects read/write, reset zero
// - Host writes each answer as full byte
// - Answer error latched, cleared by writing one
// - Answer count read-only, three once enabled
// - Question read-only, reads C once enabled
// - Status bit 0 shows transmit-low block
// - Summary bit 7 ORs every event flag
// - Summary bits 6-3 OR each event group
// - Watchdog flag sets on every watchdog error
// - Wake error sets on timer expiry in sleep
// - Bus and local wake latched, write-one clear
// - Silent and dominant latched, bits 3,1 zero
// - Per-flag mask gates the interrupt output
// - Serial port error flag, write-one clear, summarised
module qaw_device_end (
	input  wire logic  I_CLK,
	input  wire logic  I_RESET,
	qaw_link_if.device LINK,
	input  wire logic  I_WD_ENABLE,
	input  wire logic  I_WD_RESET_STATE,
	input  wire logic  I_WD_ERROR,
	input  wire logic  I_ANSWER_ERROR,
	input  wire logic  I_QUESTION_STEP,
	input  wire logic  [3:0] I_QUESTION_NEXT,
	input  wire logic  [1:0] I_ANSWER_COUNT_NEXT,
	input  wire logic  I_BUS_WAKE,
	input  wire logic  I_LOCAL_WAKE,
	input  wire logic  I_WAKE_TIMER_EXPIRED,
	input  wire logic  I_IN_SLEEP,
	input  wire logic  I_BUS_SILENT,
	input  wire logic  I_BUS_DOMINANT,
	input  wire logic  I_SERIAL_PORT_ERROR,
	input  wire logic  I_TRANSMIT_LOW_BLOCK,
	input  wire logic  I_BUS_ACTIVE,
	input  wire logic  I_BUS_SILENCE_TIME,
	input  wire logic  I_GROUP2_ANY,
	input  wire logic  I_BUS_FAULT_ANY,
	output logic       [1:0] O_ANSWER_SEL,
	output logic       [1:0] O_POLY_SEL,
	output logic       [3:0] O_SEED,
	output logic       [7:0] O_ANSWER_BYTE,
	output logic       O_ANSWER_STROBE,
	output logic       O_IRQ
);
	`include "qaw_regs.svh"

	qaw_pkg::qaw_dev_state_t st;
	qaw_pkg::qaw_dev_state_t next_st;
	logic [7:0]              wr_one;
	logic [7:0]              status_val;
	logic [7:0]              summary_val;
	logic [7:0]              int1_set;
	logic [7:0]              int3_val;
	logic                    wr;

	// ==========================================================
	// Live views
	always_comb begin
		status_val = 8'h00;
		status_val[`QAW_POS_TXD_BLOCK] = I_TRANSMIT_LOW_BLOCK;
		status_val[`QAW_POS_SILENCE_T] = I_BUS_SILENCE_TIME;
		status_val[`QAW_POS_ACTIVE] = I_BUS_ACTIVE;
		int3_val = 8'h00;
		int3_val[`QAW_POS_SPI_ERR] = st.spi_err;
		// Built from flags, never stored, so a clear drops it at once
		summary_val = 8'h00;
		summary_val[`QAW_POS_GRP1] = |st.int1;
		summary_val[`QAW_POS_GRP2] = I_GROUP2_ANY;
		summary_val[`QAW_POS_GRP3] = |int3_val;
		summary_val[`QAW_POS_GRP_BUS] = I_BUS_FAULT_ANY;
		summary_val[`QAW_POS_ANY] = |summary_val[6:3];
	end

	// ==========================================================
	// Next state
	always_comb begin
		next_st = st;
		wr = LINK.req_valid & LINK.req_write;
		wr_one = wr ? LINK.req_wdata : 8'h00;
		next_st.answer_strobe = 1'b0;

		if (wr && LINK.req_addr == `QAW_OFF_SETUP) begin
			next_st.answer_sel = LINK.req_wdata[7:6];
			next_st.poly_sel = LINK.req_wdata[5:4];
			next_st.seed_read = LINK.req_wdata[3:0];
			next_st.seed_used = LINK.req_wdata[3:0];
		end else if (wr && LINK.req_addr == `QAW_OFF_ANSWER) begin
			next_st.answer = LINK.req_wdata;
			next_st.answer_strobe = 1'b1;
		end else if (wr && LINK.req_addr == `QAW_OFF_MASK1) begin
			next_st.mask1 = LINK.req_wdata & `QAW_INT1_USED;
		end else if (wr && LINK.req_addr == `QAW_OFF_MASK3) begin
			next_st.mask3 = LINK.req_wdata[`QAW_POS_SPI_ERR];
		end

		// Question generator
		next_st.wd_en_seen = I_WD_ENABLE;
		if (I_WD_RESET_STATE) begin
			next_st.question = st.seed_used;
			next_st.ans_cnt = 2'h0;
		end else if (I_WD_ENABLE && !st.wd_en_seen) begin
			next_st.question = `QAW_Q_ENABLED;
			next_st.ans_cnt = `QAW_CNT_ENABLED;
		end else if (I_QUESTION_STEP) begin
			next_st.question = I_QUESTION_NEXT;
			next_st.ans_cnt = I_ANSWER_COUNT_NEXT;
		end

		// Sticky flags: a set in the clear cycle wins
		if (wr && LINK.req_addr == `QAW_OFF_QUESTION && wr_one[`QAW_POS_ANS_ERR]) begin
			next_st.ans_err = 1'b0;
		end
		if (I_ANSWER_ERROR) begin
			next_st.ans_err = 1'b1;
		end

		int1_set = 8'h00;
		int1_set[`QAW_POS_WD_EVENT] = I_WD_ERROR;
		int1_set[`QAW_POS_BUS_WAKE] = I_BUS_WAKE;
		int1_set[`QAW_POS_LOCAL_WAKE] = I_LOCAL_WAKE;
		int1_set[`QAW_POS_WAKE_ERR] = I_WAKE_TIMER_EXPIRED & I_IN_SLEEP;
		int1_set[`QAW_POS_SILENT] = I_BUS_SILENT;
		int1_set[`QAW_POS_DOMINANT] = I_BUS_DOMINANT;
		if (LINK.req_addr == `QAW_OFF_INT1) begin
			next_st.int1 = st.int1 & ~wr_one;
		end
		next_st.int1 = (next_st.int1 | int1_set) & `QAW_INT1_USED;

		if (LINK.req_addr == `QAW_OFF_INT3 && wr_one[`QAW_POS_SPI_ERR]) begin
			next_st.spi_err = 1'b0;
		end
		if (I_SERIAL_PORT_ERROR) begin
			next_st.spi_err = 1'b1;
		end

		next_st.irq = |(st.int1 & st.mask1) | (st.spi_err & st.mask3);

		// Read answer, one cycle after the request
		next_st.rsp_valid = LINK.req_valid;
		next_st.rsp_rdata = 8'h00;
		if (LINK.req_valid && !LINK.req_write) begin
			if (LINK.req_addr == `QAW_OFF_SETUP) begin
				next_st.rsp_rdata = {st.answer_sel, st.poly_sel, st.seed_read};
			end else if (LINK.req_addr == `QAW_OFF_ANSWER) begin
				next_st.rsp_rdata = st.answer;
			end else if (LINK.req_addr == `QAW_OFF_QUESTION) begin
				next_st.rsp_rdata = {1'b0, st.ans_err, st.ans_cnt, st.question};
			end else if (LINK.req_addr == `QAW_OFF_STATUS) begin
				next_st.rsp_rdata = status_val;
			end else if (LINK.req_addr == `QAW_OFF_SUMMARY) begin
				next_st.rsp_rdata = summary_val;
			end else if (LINK.req_addr == `QAW_OFF_INT1) begin
				next_st.rsp_rdata = st.int1;
			end else if (LINK.req_addr == `QAW_OFF_INT3) begin
				next_st.rsp_rdata = int3_val;
			end else if (LINK.req_addr == `QAW_OFF_MASK1) begin
				next_st.rsp_rdata = st.mask1;
			end else if (LINK.req_addr == `QAW_OFF_MASK3) begin
				next_st.rsp_rdata = {st.mask3, 7'h00};
			end
		end
	end

	// ==========================================================
	// State register
	always_ff @(posedge I_CLK or posedge I_RESET) begin
		if (I_RESET) begin
			st <= '0;
			st.seed_used <= `QAW_SEED_POWERUP;
			st.mask1 <= `QAW_MASK1_RESET;
			st.mask3 <= 1'b1;
		end else begin
			st <= next_st;
		end
	end

	// ==========================================================
	// Outputs
	assign LINK.rsp_valid = st.rsp_valid;
	assign LINK.rsp_rdata = st.rsp_rdata;
	assign LINK.irq = st.irq;
	assign O_ANSWER_SEL = st.answer_sel;
	assign O_POLY_SEL = st.poly_sel;
	assign O_SEED = st.seed_used;
	assign O_ANSWER_BYTE = st.answer;
	assign O_ANSWER_STROBE = st.answer_strobe;
	assign O_IRQ = st.irq;

endmodule : qaw_device_end

// ===== core/qaw_host_end.sv
// Host end: AXI4-Lite command registers driving the device register link
`timescale 1ns/1ps
module qaw_host_end (
	input  wire logic  I_CLK,
	input  wire logic  I_RESET,
	qaw_link_if.host   LINK,
	input  wire logic  [11:0] I_AWADDR,
	input  wire logic  I_AWVALID,
	output logic       O_AWREADY,
	input  wire logic  [31:0] I_WDATA,
	input  wire logic  [3:0] I_WSTRB,
	input  wire logic  I_WVALID,
	output logic       O_WREADY,
	output logic       [1:0] O_BRESP,
	output logic       O_BVALID,
	input  wire logic  I_BREADY,
	input  wire logic  [11:0] I_ARADDR,
	input  wire logic  I_ARVALID,
	output logic       O_ARREADY,
	output logic       [31:0] O_RDATA,
	output logic       [1:0] O_RRESP,
	output logic       O_RVALID,
	input  wire logic  I_RREADY,
	output logic       O_IRQ
);
	`include "qaw_regs.svh"

	qaw_pkg::qaw_host_state_s_t st;
	qaw_pkg::qaw_host_state_s_t next_st;
	logic                       do_wr;
	logic                       done;
	logic [1:0]                 ev;

	always_comb begin
		next_st = st;
		ev = 2'h0;
		done = 1'b0;
		next_st.req_valid = 1'b0;

		// ==========================================================
		// AXI write channel, both halves in either order
		if (I_AWVALID && st.awready) begin
			next_st.have_aw = 1'b1;
			next_st.aw_addr = I_AWADDR;
		end
		if (I_WVALID && st.wready) begin
			next_st.have_w = 1'b1;
			next_st.w_data = I_WDATA;
			next_st.w_strb = I_WSTRB;
		end
		if (st.bvalid && I_BREADY) begin
			next_st.bvalid = 1'b0;
		end
		do_wr = st.have_aw && st.have_w && !st.bvalid;

		// ==========================================================
		// Link sequencer; a go while busy is dropped
		case (st.fsm)
			qaw_pkg::QAW_IDLE: begin
				if (do_wr && st.aw_addr == `QAW_HOFF_GO && st.w_strb[0] && st.w_data[0]) begin
					next_st.write = st.w_data[1];
					next_st.req_valid = 1'b1;
					next_st.fsm = qaw_pkg::QAW_REQ;
				end
			end
			qaw_pkg::QAW_REQ: begin
				next_st.fsm = qaw_pkg::QAW_WAIT;
			end
			qaw_pkg::QAW_WAIT: begin
				if (LINK.rsp_valid) begin
					next_st.rdata = LINK.rsp_rdata;
					done = 1'b1;
					next_st.fsm = qaw_pkg::QAW_IDLE;
				end
			end
			default: begin
				next_st.fsm = qaw_pkg::QAW_IDLE;
			end
		endcase

		ev[`QAW_HIRQ_DONE] = done;
		ev[`QAW_HIRQ_DEVICE] = LINK.irq & ~st.dev_irq_d;
		next_st.dev_irq_d = LINK.irq;

		if (do_wr) begin
			next_st.have_aw = 1'b0;
			next_st.have_w = 1'b0;
			next_st.bvalid = 1'b1;
			next_st.bresp = `QAW_RESP_OKAY;
			if (st.aw_addr == `QAW_HOFF_ADDR) begin
				if (st.w_strb[0]) next_st.addr = st.w_data[7:0];
			end else if (st.aw_addr == `QAW_HOFF_WDATA) begin
				if (st.w_strb[0]) next_st.wdata = st.w_data[7:0];
			end else if (st.aw_addr == `QAW_HOFF_IRQ_STAT) begin
				if (st.w_strb[0]) next_st.irq_stat = st.irq_stat & ~st.w_data[1:0];
			end else if (st.aw_addr == `QAW_HOFF_IRQ_MASK) begin
				if (st.w_strb[0]) next_st.irq_mask = st.w_data[1:0];
			end else if (st.aw_addr != `QAW_HOFF_GO && st.aw_addr != `QAW_HOFF_STAT) begin
				next_st.bresp = `QAW_RESP_SLVERR;
			end
		end
		// Set wins over a clear in the same cycle
		next_st.irq_stat = next_st.irq_stat | ev;
		next_st.irq = |(st.irq_stat & st.irq_mask);
		next_st.awready = !next_st.have_aw && !next_st.bvalid;
		next_st.wready = !next_st.have_w && !next_st.bvalid;

		// ==========================================================
		// AXI read channel
		if (st.rvalid && I_RREADY) begin
			next_st.rvalid = 1'b0;
		end
		if (I_ARVALID && st.arready) begin
			next_st.rvalid = 1'b1;
			next_st.rresp = `QAW_RESP_OKAY;
			next_st.rdata_bus = 32'h00000000;
			if (I_ARADDR == `QAW_HOFF_ADDR) begin
				next_st.rdata_bus = {24'h000000, st.addr};
			end else if (I_ARADDR == `QAW_HOFF_WDATA) begin
				next_st.rdata_bus = {24'h000000, st.wdata};
			end else if (I_ARADDR == `QAW_HOFF_GO) begin
				next_st.rdata_bus = {30'h00000000, st.write, 1'b0};
			end else if (I_ARADDR == `QAW_HOFF_STAT) begin
				next_st.rdata_bus = {16'h0000, st.rdata, 7'h00, st.fsm != qaw_pkg::QAW_IDLE};
			end else if (I_ARADDR == `QAW_HOFF_IRQ_STAT) begin
				next_st.rdata_bus = {30'h00000000, st.irq_stat};
			end else if (I_ARADDR == `QAW_HOFF_IRQ_MASK) begin
				next_st.rdata_bus = {30'h00000000, st.irq_mask};
			end else begin
				next_st.rresp = `QAW_RESP_SLVERR;
			end
		end
		next_st.arready = !next_st.rvalid;
	end

	always_ff @(posedge I_CLK or posedge I_RESET) begin
		if (I_RESET) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign LINK.req_valid = st.req_valid;
	assign LINK.req_write = st.write;
	assign LINK.req_addr = st.addr;
	assign LINK.req_wdata = st.wdata;
	assign O_AWREADY = st.awready;
	assign O_WREADY = st.wready;
	assign O_BRESP = st.bresp;
	assign O_BVALID = st.bvalid;
	assign O_ARREADY = st.arready;
	assign O_RDATA = st.rdata_bus;
	assign O_RRESP = st.rresp;
	assign O_RVALID = st.rvalid;
	assign O_IRQ = st.irq;

endmodule : qaw_host_end

// ===== testbench/qaw_link_chk.sv
// Link checker: request and response timing and register read rules
`timescale 1ns/1ps
module qaw_link_chk (
	input wire logic       I_CLK,
	input wire logic       I_RESET,
	input wire logic       req_valid,
	input wire logic       req_write,
	input wire logic [7:0] req_addr,
	input wire logic [7:0] req_wdata,
	input wire logic       rsp_valid,
	input wire logic [7:0] rsp_rdata,
	input wire logic       irq
);
	`include "qaw_regs.svh"

	default clocking cb @(posedge I_CLK);
	endclocking
	default disable iff (I_RESET);
	// ==========================================================
	// Helper state
	logic       rd_pend;
	logic [7:0] rd_addr;
	logic [7:0] setup_sh;
	logic [7:0] ans_sh;
	always_ff @(posedge I_CLK or posedge I_RESET) begin
		if (I_RESET) begin
			rd_pend  <= 1'b0;
			rd_addr  <= 8'h00;
			setup_sh <= 8'h00;
			ans_sh   <= 8'h00;
		end else begin
			rd_pend <= req_valid && !req_write;
			if (req_valid)
				rd_addr <= req_addr;
			if (req_valid && req_write && req_addr == `QAW_OFF_SETUP)
				setup_sh <= req_wdata;
			if (req_valid && req_write && req_addr == `QAW_OFF_ANSWER)
				ans_sh <= req_wdata;
		end
	end
	// ==========================================================
	// Timing and read rules
	rsp_follows_req_a: assert property (req_valid |=> rsp_valid)
		else $error("no response one cycle after a request");
	rsp_single_a: assert property (rsp_valid |=> !rsp_valid)
		else $error("response longer than one cycle");
	rsp_cause_a: assert property (rsp_valid |-> $past(req_valid))
		else $error("response without a request");
	req_spacing_a: assert property (req_valid |=> !req_valid [*2])
		else $error("requests closer than three cycles");
	write_quiet_a: assert property (rsp_valid && !rd_pend |-> rsp_rdata == 8'h00)
		else $error("write response carries data");
	setup_readback_a: assert property (
		rsp_valid && rd_pend && rd_addr == `QAW_OFF_SETUP |-> rsp_rdata == setup_sh)
		else $error("setup read differs from last write");
	answer_readback_a: assert property (
		rsp_valid && rd_pend && rd_addr == `QAW_OFF_ANSWER |-> rsp_rdata == ans_sh)
		else $error("answer read differs from last write");
	question_rsvd_a: assert property (
		rsp_valid && rd_pend && rd_addr == `QAW_OFF_QUESTION |-> !rsp_rdata[7])
		else $error("question reserved bit set");
	event_rsvd_a: assert property (
		rsp_valid && rd_pend && rd_addr == `QAW_OFF_INT1
		|-> rsp_rdata[3] == 1'b0 && rsp_rdata[1] == 1'b0)
		else $error("event reserved bits set");
	summary_or_a: assert property (
		rsp_valid && rd_pend && rd_addr == `QAW_OFF_SUMMARY
		|-> (rsp_rdata[7] == |rsp_rdata[6:3]) && rsp_rdata[2:0] == 3'h0)
		else $error("summary top bit not the group OR");
	status_rsvd_a: assert property (
		rsp_valid && rd_pend && rd_addr == `QAW_OFF_STATUS
		|-> rsp_rdata[7:4] == 4'h0 && !rsp_rdata[1])
		else $error("status reserved bits set");
	// Interrupt and answer must both come out of reset quiet
	reset_quiet_a: assert property ($fell(I_RESET) |-> !irq && !rsp_valid)
		else $error("interrupt or response right after reset");
endmodule : qaw_link_chk

// ===== testbench/qa_watchdog_status_event_regs_tb.sv
// Bench: AXI4-Lite host end driving the device end, against a register model
`timescale 1ns/1ps
`include "qaw_regs.svh"
module qa_watchdog_status_event_regs_tb;
	logic        I_CLK = 1'b0, I_RESET = 1'b1;
	logic [11:0] awaddr = 12'h000, araddr = 12'h000;
	logic [31:0] wdata = 32'h0, rdata, s;
	logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic        awready, wready, bvalid, arready, rvalid, h_irq, d_irq, strobe;
	logic [1:0]  bresp, rresp, asel, psel, r;
	logic [7:0]  ev = 8'h00, ans_b;
	logic        wd_en = 1'b0, wd_rst = 1'b0, sleep = 1'b0, step = 1'b0, g2 = 1'b0, bf = 1'b0;
	logic        txl = 1'b0, act = 1'b0, sil = 1'b0;
	logic [3:0]  qn = 4'h0, seed_o;
	logic [1:0]  cn = 2'h0;
	logic [31:0] rng = 32'h00016d48, d;
	logic [7:0]  regs [10] = '{8'h2d, 8'h2e, 8'h2f, 8'h40, 8'h50, 8'h51, 8'h53, 8'h56, 8'h58, 8'h60};
	logic [7:0]  evs [6] = '{8'h80, 8'h40, 8'h20, 8'h10, 8'h04, 8'h01};
	int          mdl [256];
	int          seed, strobes, exp_strobes, bad_count, tests_run, cycles;
	qaw_link_if link ();
	qaw_device_end i_qaw_device_end (.I_CLK(I_CLK), .I_RESET(I_RESET), .LINK(link),
		.I_WD_ENABLE(wd_en), .I_WD_RESET_STATE(wd_rst), .I_WD_ERROR(ev[7]), .I_ANSWER_ERROR(ev[3]),
		.I_QUESTION_STEP(step), .I_QUESTION_NEXT(qn), .I_ANSWER_COUNT_NEXT(cn), .I_BUS_WAKE(ev[6]),
		.I_LOCAL_WAKE(ev[5]), .I_WAKE_TIMER_EXPIRED(ev[4]), .I_IN_SLEEP(sleep), .I_BUS_SILENT(ev[2]),
		.I_BUS_DOMINANT(ev[0]), .I_SERIAL_PORT_ERROR(ev[1]), .I_TRANSMIT_LOW_BLOCK(txl),
		.I_BUS_ACTIVE(act), .I_BUS_SILENCE_TIME(sil), .I_GROUP2_ANY(g2), .I_BUS_FAULT_ANY(bf),
		.O_ANSWER_SEL(asel), .O_POLY_SEL(psel), .O_SEED(seed_o), .O_ANSWER_BYTE(ans_b),
		.O_ANSWER_STROBE(strobe), .O_IRQ(d_irq));
	qaw_host_end i_qaw_host_end (.I_CLK(I_CLK), .I_RESET(I_RESET), .LINK(link), .I_AWADDR(awaddr),
		.I_AWVALID(awvalid), .O_AWREADY(awready), .I_WDATA(wdata), .I_WSTRB(4'h1), .I_WVALID(wvalid),
		.O_WREADY(wready), .O_BRESP(bresp), .O_BVALID(bvalid), .I_BREADY(bready), .I_ARADDR(araddr),
		.I_ARVALID(arvalid), .O_ARREADY(arready), .O_RDATA(rdata), .O_RRESP(rresp), .O_RVALID(rvalid),
		.I_RREADY(rready), .O_IRQ(h_irq));
	qaw_link_chk i_qaw_link_chk (.I_CLK(I_CLK), .I_RESET(I_RESET), .req_valid(link.req_valid),
		.req_write(link.req_write), .req_addr(link.req_addr), .req_wdata(link.req_wdata),
		.rsp_valid(link.rsp_valid), .rsp_rdata(link.rsp_rdata), .irq(link.irq));
	// ==========================================================
	// Clock, timeout, strobe count
	always #20 I_CLK = ~I_CLK;
	always @(posedge I_CLK) begin
		cycles++;
		if (strobe === 1'b1)
			strobes++;
		if (cycles == 30000) begin
			bad_count++;
			end_sim();
		end
	end
	// ==========================================================
	// Bus tasks and model
	function logic [31:0] rnd();
		rng ^= rng << 13;
		rng ^= rng >> 17;
		rng ^= rng << 5;
		return rng;
	endfunction : rnd
	task chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			bad_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task axi_wr(input logic [11:0] a, input logic [31:0] v, output logic [1:0] resp);
		@(posedge I_CLK);
		awaddr <= a;
		wdata <= v;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge I_CLK);
			if (awready)
				awvalid <= 1'b0;
			if (wready)
				wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		resp = bresp;
		bready <= 1'b0;
	endtask : axi_wr
	task axi_rd(input logic [11:0] a, output logic [31:0] v);
		@(posedge I_CLK);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge I_CLK);
			if (arready)
				arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		v = rdata;
		rready <= 1'b0;
	endtask : axi_rd
	// Polls busy rather than counting cycles, so host latency stays free
	task link_op(input logic w, input logic [7:0] a, input logic [7:0] v, output logic [7:0] q);
		axi_wr(`QAW_HOFF_WDATA, {24'h0, v}, r);
		axi_wr(`QAW_HOFF_ADDR, {24'h0, a}, r);
		axi_wr(`QAW_HOFF_GO, {30'h0, w, 1'b1}, r);
		chk(r, `QAW_RESP_OKAY);
		do
			axi_rd(`QAW_HOFF_STAT, s);
		while (s[0] !== 1'b0);
		q = s[15:8];
	endtask : link_op
	task wr(input logic [7:0] a, input logic [7:0] v);
		logic [7:0] q;
		link_op(1'b1, a, v, q);
		case (a)
			8'h2d: seed = v[3:0];
			8'h2e: exp_strobes++;
			default: ;
		endcase
		case (a)
			8'h2d, 8'h2e: mdl[a] = v;
			8'h2f: mdl[a] &= ~(v & 8'h40);
			8'h51: mdl[a] &= ~(v & 8'hf5);
			8'h53, 8'h58: mdl[a] = (a == 8'h53) ? mdl[a] & ~(v & 8'h80) : v & 8'h80;
			8'h56: mdl[a] = v & 8'hf5;
			default: ;
		endcase
	endtask : wr
	task rd(input logic [7:0] a);
		logic [7:0] q;
		logic g1, g3;
		link_op(1'b0, a, 8'h00, q);
		g1 = mdl[8'h51] != 0;
		g3 = mdl[8'h53] != 0;
		mdl[8'h40] = {4'h0, act, sil, 1'b0, txl};
		mdl[8'h50] = {g1 | g2 | g3 | bf, g1, g2, g3, bf, 3'h0};
		chk(q, mdl[a][7:0]);
		chk(d_irq, |(mdl[8'h51] & mdl[8'h56]) | (mdl[8'h53][7] & mdl[8'h58][7]));
	endtask : rd
	task pulse(input logic [7:0] m);
		@(posedge I_CLK);
		ev <= m;
		@(posedge I_CLK);
		ev <= 8'h00;
		if (m[3])
			mdl[8'h2f] |= 8'h40;
		if (m[1])
			mdl[8'h53] |= 8'h80;
		mdl[8'h51] |= m & (sleep ? 8'hf5 : 8'he5);
	endtask : pulse
	task end_sim();
		$display("comparisons %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : end_sim
	// ==========================================================
	// Scenarios
	initial begin
		mdl = '{default: 0};
		mdl[8'h56] = 8'hf3;
		mdl[8'h58] = 8'h80;
		seed = 5;
		repeat (3) @(posedge I_CLK);
		I_RESET <= 1'b0;
		for (int i = 0; i < 10; i++)
			rd(regs[i]);
		chk(seed_o, 4'h5);
		$display("reset values done");
		for (int i = 0; i < 4; i++) begin
			d = rnd();
			wr(8'h2d, d[7:0]);
			rd(8'h2d);
			chk({asel, psel, seed_o}, d[7:0]);
		end
		$display("setup done");
		wd_rst <= 1'b1;
		repeat (2) @(posedge I_CLK);
		wd_rst <= 1'b0;
		mdl[8'h2f] = seed;
		rd(8'h2f);
		d = rnd();
		qn <= d[3:0];
		cn <= d[5:4];
		step <= 1'b1;
		@(posedge I_CLK);
		step <= 1'b0;
		mdl[8'h2f] = d[5:0];
		rd(8'h2f);
		wd_en <= 1'b1;
		mdl[8'h2f] = 8'h3c;
		rd(8'h2f);
		wr(8'h2f, 8'hbf);
		rd(8'h2f);
		$display("question done");
		for (int i = 0; i < 3; i++) begin
			d = rnd();
			wr(8'h2e, d[7:0]);
			rd(8'h2e);
			chk(ans_b, d[7:0]);
		end
		chk(strobes, exp_strobes);
		pulse(8'h08);
		rd(8'h2f);
		wr(8'h2f, 8'h40);
		rd(8'h2f);
		pulse(8'h10);
		rd(8'h51);
		sleep <= 1'b1;
		for (int i = 0; i < 6; i++) begin
			pulse(evs[i]);
			rd(8'h51);
			rd(8'h50);
			wr(8'h51, evs[i]);
			rd(8'h50);
		end
		pulse(8'hf5);
		rd(8'h51);
		wr(8'h51, 8'hff);
		rd(8'h51);
		$display("events done");
		wr(8'h56, 8'h00);
		pulse(8'h80);
		rd(8'h56);
		wr(8'h56, 8'hff);
		rd(8'h56);
		wr(8'h51, 8'h80);
		pulse(8'h02);
		rd(8'h53);
		rd(8'h50);
		wr(8'h53, 8'h80);
		rd(8'h53);
		g2 <= 1'b1;
		rd(8'h50);
		g2 <= 1'b0;
		bf <= 1'b1;
		rd(8'h50);
		bf <= 1'b0;
		rd(8'h50);
		$display("mask and summary done");
		for (int i = 0; i < 4; i++) begin
			d = rnd();
			{txl, act, sil} <= d[2:0];
			rd(8'h40);
			wr(8'h40, 8'hff);
			rd(8'h40);
		end
		$display("status done");
		axi_wr(12'h020, 32'h1, r);
		chk(r, `QAW_RESP_SLVERR);
		axi_rd(12'h020, s);
		chk(s, 32'h0);
		chk(rresp, `QAW_RESP_SLVERR);
		axi_rd(`QAW_HOFF_IRQ_STAT, s);
		chk(s, 32'h3);
		axi_wr(`QAW_HOFF_IRQ_STAT, 32'h3, r);
		axi_rd(`QAW_HOFF_IRQ_STAT, s);
		chk(s, 32'h0);
		axi_wr(`QAW_HOFF_IRQ_MASK, 32'h1, r);
		chk(h_irq, 1'b0);
		rd(8'h2d);
		repeat (2) @(posedge I_CLK);
		chk(h_irq, 1'b1);
		axi_wr(`QAW_HOFF_IRQ_STAT, 32'h1, r);
		repeat (2) @(posedge I_CLK);
		chk(h_irq, 1'b0);
		$display("host bus done");
		end_sim();
	end
endmodule : qa_watchdog_status_event_regs_tb
